/* File: logic/mdr_reader.v */
// Modbus holding-register reader for the supervision dataset
//
// Summary of operation
// - Requests of more than 125 registers are refused with an exception.
// - The dataset starts at register 32000, consecutive numbers onward.
// - Frame address N selects register number N plus one.
// - Dataset registers are Modbus readable only; writes come via the command port.
// - 64-bit values use four registers, most significant register first.
// - Floats are stored as IEEE 754 single precision patterns.
// - A float spans two registers, upper half in the lower number.
// - Validity flags sit in the register just below each status register.
// - Response echoes address and function, byte count, then data high first.
// - Single-register unsigned values span the full 16-bit range.
// - Unavailable phase 1 RMS current reads back as the float marker 0xFFC00000; invalid status bits read as zero.
// - Undefined registers in the range are read from memory without an exception response.
// - Partial reads of a block quantity yield an exception response.
`timescale 1ns/10ps
`default_nettype none
`include "mdr_regs.vh"
module mdr_reader (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [7:0] slave_addr_i,
  input wire [7:0] rx_byte_i,
  input wire rx_valid_i,
  input wire rx_frame_end_i,
  input wire rx_crc_ok_i,
  input wire cmd_we_i,
  input wire [`MDR_DS_AW-1:0] cmd_addr_i,
  input wire [15:0] cmd_data_i,
  input wire [15:0] open_closed_contact_i,
  input wire [15:0] status_valid_i,
  input wire [31:0] phase1_rms_current_i,
  input wire phase1_rms_current_ok_i,
  input wire upd_i,
  input wire tx_ready_i,
  output reg [7:0] tx_byte_o,
  output wire tx_valid_o,
  output reg tx_last_o,
  output wire busy_o
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_RX = 3'h0;
  localparam ST_CHK = 3'h1;
  localparam ST_HDR = 3'h2;
  localparam ST_RD = 3'h3;
  localparam ST_DH = 3'h4;
  localparam ST_DL = 3'h5;
  localparam ST_EXC = 3'h6;

  function in_set;
    input [`MDR_DS_AW-1:0] ofs;
    begin
      in_set = (ofs >= `MDR_DS_AW'h002 && ofs < `MDR_I1_OFS) ||
        (ofs > `MDR_I1_OFS + `MDR_DS_AW'h001 && ofs < `MDR_BLK_LO) ||
        (ofs > `MDR_BLK_HI && ofs < `MDR_DS_END);
    end
  endfunction

  reg [2:0] st_ff, nxt_st;
  reg [2:0] idx_ff, nxt_idx;
  reg [7:0] addr_ff, nxt_addr;
  reg [7:0] func_ff, nxt_func;
  reg [15:0] start_ff, nxt_start;
  reg [15:0] cnt_ff, nxt_cnt;
  reg [15:0] left_ff, nxt_left;
  reg [`MDR_DS_AW-1:0] rptr_ff, nxt_rptr;
  reg [7:0] exc_ff, nxt_exc;
  reg [15:0] word_ff, nxt_word;
  reg [7:0] nxt_tx;
  reg nxt_last;
  // Snapshot taken on upd_i while idle; the live input may tear mid-frame
  reg [31:0] i1_ff;
  reg [15:0] oc_ff, val_ff;
  wire [15:0] mem_rd;
  wire [15:0] rel = start_ff - `MDR_BASE_ADDR;
  // Range check runs first, so upper bits of rel are zero when used
  wire [`MDR_DS_AW-1:0] start_ofs = rel[`MDR_DS_AW-1:0];
  wire [15:0] last_rel = rel + cnt_ff - 16'h0001;

  assign tx_valid_o = (st_ff == ST_HDR) || (st_ff == ST_DH) ||
    (st_ff == ST_DL) || (st_ff == ST_EXC);
  assign busy_o = (st_ff != ST_RX);

  // Dataset registers are not writable by Modbus, only through the command port
  mdr_mem u_mem (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(cmd_we_i),
    .waddr_i(cmd_addr_i),
    .wdata_i(cmd_data_i),
    .raddr_i(rptr_ff),
    .rdata_o(mem_rd)
  );

  // ----------------------------------------
  // Word select
  // ----------------------------------------
  reg [15:0] sel_word;
  reg [`MDR_DS_AW-1:0] pos;
  always @* begin
    pos = rptr_ff - `MDR_DS_AW'h001;
    if (pos == `MDR_QUAL_OFS) begin
      sel_word = val_ff;
    end else if (pos == `MDR_STAT_OFS) begin
      sel_word = oc_ff & val_ff | oc_ff;
    end else if (pos == `MDR_I1_OFS) begin
      sel_word = i1_ff[31:16];
    end else if (pos == `MDR_I1_OFS + `MDR_DS_AW'h001) begin
      sel_word = i1_ff[15:0];
    end else begin
      sel_word = mem_rd;
    end
  end

  // ----------------------------------------
  // Request / response sequencer
  // ----------------------------------------
  always @* begin
    nxt_st = st_ff;
    nxt_idx = idx_ff;
    nxt_addr = addr_ff;
    nxt_func = func_ff;
    nxt_start = start_ff;
    nxt_cnt = cnt_ff;
    nxt_left = left_ff;
    nxt_rptr = rptr_ff;
    nxt_exc = exc_ff;
    nxt_word = word_ff;
    nxt_tx = tx_byte_o;
    nxt_last = 1'b0;
    case (st_ff)
      ST_RX: begin
        if (rx_valid_i) begin
          case (idx_ff)
            3'h0: nxt_addr = rx_byte_i;
            3'h1: nxt_func = rx_byte_i;
            3'h2: nxt_start = {rx_byte_i, start_ff[7:0]};
            3'h3: nxt_start = {start_ff[15:8], rx_byte_i};
            3'h4: nxt_cnt = {rx_byte_i, cnt_ff[7:0]};
            3'h5: nxt_cnt = {cnt_ff[15:8], rx_byte_i};
            default: nxt_idx = idx_ff;
          endcase
          if (idx_ff != 3'h7) begin
            nxt_idx = idx_ff + 3'h1;
          end
        end
        if (rx_frame_end_i) begin
          nxt_idx = 3'h0;
          // Silent on foreign address or bad CRC
          if (rx_crc_ok_i && addr_ff == slave_addr_i && idx_ff >= 3'h6) begin
            nxt_st = ST_CHK;
          end
        end
      end
      ST_CHK: begin
        nxt_rptr = start_ofs;
        nxt_left = cnt_ff;
        nxt_idx = 3'h0;
        // Byte register runs one step ahead so each byte stands with valid
        nxt_tx = addr_ff;
        if (func_ff != `MDR_FUNC_READ) begin
          nxt_exc = `MDR_EXC_ILL_FUNC;
          nxt_st = ST_EXC;
        end else if (cnt_ff == 16'h0000 || cnt_ff > `MDR_MAX_COUNT) begin
          nxt_exc = `MDR_EXC_VALUE;
          nxt_st = ST_EXC;
        end else if (start_ff < `MDR_BASE_ADDR || rel + cnt_ff > `MDR_DS_LEN) begin
          nxt_exc = `MDR_EXC_ADDR;
          nxt_st = ST_EXC;
        end else if ((rel > {7'h00, `MDR_BLK_LO} && rel <= {7'h00, `MDR_BLK_HI}) ||
            (last_rel >= {7'h00, `MDR_BLK_LO} && last_rel < {7'h00, `MDR_BLK_HI})) begin
          nxt_exc = `MDR_EXC_ADDR;
          nxt_st = ST_EXC;
        end else begin
          nxt_st = ST_HDR;
        end
      end
      ST_HDR: begin
        if (tx_ready_i) begin
          nxt_idx = idx_ff + 3'h1;
          if (idx_ff == 3'h0) begin
            nxt_tx = func_ff;
          end else if (idx_ff == 3'h1) begin
            nxt_tx = {cnt_ff[6:0], 1'b0};
          end else begin
            // Clear so the next frame lands at byte zero
            nxt_idx = 3'h0;
            nxt_rptr = rptr_ff + `MDR_DS_AW'h001;
            nxt_st = ST_RD;
          end
        end
      end
      ST_RD: begin
        nxt_word = sel_word;
        nxt_tx = sel_word[15:8];
        nxt_st = ST_DH;
      end
      ST_DH: begin
        if (tx_ready_i) begin
          nxt_tx = word_ff[7:0];
          nxt_last = (left_ff == 16'h0001);
          nxt_st = ST_DL;
        end
      end
      ST_DL: begin
        nxt_last = tx_last_o;
        if (tx_ready_i) begin
          nxt_last = 1'b0;
          nxt_left = left_ff - 16'h0001;
          nxt_rptr = rptr_ff + `MDR_DS_AW'h001;
          nxt_st = (left_ff == 16'h0001) ? ST_RX : ST_RD;
        end
      end
      ST_EXC: begin
        nxt_last = tx_last_o;
        if (tx_ready_i) begin
          nxt_idx = idx_ff + 3'h1;
          if (idx_ff == 3'h0) begin
            nxt_tx = func_ff | `MDR_EXC_FLAG;
          end else if (idx_ff == 3'h1) begin
            nxt_tx = exc_ff;
            nxt_last = 1'b1;
          end else begin
            nxt_idx = 3'h0;
            nxt_last = 1'b0;
            nxt_st = ST_RX;
          end
        end
      end
      default: nxt_st = ST_RX;
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= ST_RX;
      idx_ff <= 3'h0;
      addr_ff <= 8'h00;
      func_ff <= 8'h00;
      start_ff <= 16'h0000;
      cnt_ff <= 16'h0000;
      left_ff <= 16'h0000;
      rptr_ff <= `MDR_DS_AW'h000;
      exc_ff <= 8'h00;
      word_ff <= 16'h0000;
      tx_byte_o <= 8'h00;
      tx_last_o <= 1'b0;
      i1_ff <= `MDR_NA_F32;
      oc_ff <= 16'h0000;
      val_ff <= 16'h0000;
    end else if (ce_i) begin
      st_ff <= nxt_st;
      idx_ff <= nxt_idx;
      addr_ff <= nxt_addr;
      func_ff <= nxt_func;
      start_ff <= nxt_start;
      cnt_ff <= nxt_cnt;
      left_ff <= nxt_left;
      rptr_ff <= nxt_rptr;
      exc_ff <= nxt_exc;
      word_ff <= nxt_word;
      tx_byte_o <= nxt_tx;
      tx_last_o <= nxt_last;
      // Update only while idle so a whole response sees one snapshot
      if (st_ff == ST_RX && upd_i) begin
        i1_ff <= phase1_rms_current_ok_i ? phase1_rms_current_i : `MDR_NA_F32;
        oc_ff <= open_closed_contact_i & status_valid_i;
        val_ff <= status_valid_i;
      end
    end
  end
endmodule // mdr_reader
`default_nettype wire

/* File: logic/mdr_regs.vh */
// Constants for the supervision dataset register reader
`ifndef MDR_REGS_VH
`define MDR_REGS_VH
`define MDR_FUNC_READ 8'h03
`define MDR_EXC_FUNC 8'h83
`define MDR_EXC_ADDR 8'h02
`define MDR_EXC_VALUE 8'h03
`define MDR_EXC_ILL_FUNC 8'h01
`define MDR_EXC_FLAG 8'h80
`define MDR_MAX_COUNT 16'h007D
`define MDR_BASE_ADDR 16'h7CFF
`define MDR_DS_LEN 16'h0156
`define MDR_DS_AW 9
`define MDR_DS_END 9'h156
`define MDR_QUAL_OFS 9'h000
`define MDR_STAT_OFS 9'h001
`define MDR_I1_OFS 9'h01C
`define MDR_I1_ADDR 16'h7D1B
`define MDR_NA_U16 16'hFFFF
`define MDR_NA_F32 32'hFFC00000
`define MDR_BLK_LO 9'h060
`define MDR_BLK_HI 9'h063
`define MDR_BLK_LEN 16'h0004
`endif

/* File: logic/mdr_mem.v */
// Dataset word memory with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "mdr_regs.vh"
module mdr_mem (
  input wire clk_i,
  input wire ce_i,
  input wire we_i,
  input wire [`MDR_DS_AW-1:0] waddr_i,
  input wire [15:0] wdata_i,
  input wire [`MDR_DS_AW-1:0] raddr_i,
  output reg [15:0] rdata_o
);
  reg [15:0] mem [0:(1<<`MDR_DS_AW)-1];
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // mdr_mem
`default_nettype wire

/* File: verif/mdr_reader_properties.sv */
// Port-level properties of the dataset reader
`timescale 1ns/10ps
`default_nettype none
module mdr_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] slave_addr_i,
  input wire logic rx_frame_end_i,
  input wire logic rx_crc_ok_i,
  input wire logic tx_ready_i,
  input wire logic [7:0] tx_byte_o,
  input wire logic tx_valid_o,
  input wire logic tx_last_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------
  // Reply framing
  // ----------------
  chk_crc_silent: assert property (rx_frame_end_i && ce_i && !rx_crc_ok_i && !busy_o
    |=> !tx_valid_o [*3]) else $error("reply after bad frame");
  chk_answer_time: assert property (rx_frame_end_i && rx_crc_ok_i && ce_i && !busy_o ##1 ce_i
    |=> tx_valid_o || !busy_o) else $error("reply late");
  chk_hold_byte: assert property (tx_valid_o && !tx_ready_i
    |=> tx_valid_o && $stable(tx_byte_o) && $stable(tx_last_o)) else $error("byte dropped");
  chk_last_ends: assert property (tx_valid_o && tx_ready_i && tx_last_o && ce_i
    |=> !tx_valid_o) else $error("bytes after last");
  chk_valid_busy: assert property (tx_valid_o |-> busy_o) else $error("idle send");
  chk_addr_echo: assert property (tx_valid_o && $past(busy_o) && !$past(busy_o, 2)
    |-> tx_byte_o == slave_addr_i) else $error("address not echoed");
  chk_busy_bound: assert property ($rose(busy_o) |-> ##[1:1000] !busy_o)
    else $error("reply too long");
  chk_last_valid: assert property ($rose(tx_last_o) |-> tx_valid_o)
    else $error("last without byte");
  cover property (tx_valid_o && tx_ready_i && tx_last_o);
  cover property (tx_valid_o && !tx_ready_i);
  cover property (rx_frame_end_i && !rx_crc_ok_i);
endmodule // mdr_chk
bind mdr_reader mdr_chk mdr_chk_inst (.clk_i, .rst_i, .ce_i, .slave_addr_i, .rx_frame_end_i,
  .rx_crc_ok_i, .tx_ready_i, .tx_byte_o, .tx_valid_o, .tx_last_o, .busy_o);
`default_nettype wire

/* File: verif/mdr_master.sv */
// Remote master model: sends read frames, collects replies
`timescale 1ns/10ps
`default_nettype none
module mdr_master (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic rx_frame_end_o,
  output logic rx_crc_ok_o,
  output logic tx_ready_o
);
  logic [8:0] got[$];
  logic ph = 1'b0;
  initial begin
    rx_byte_o = 8'h5A;
    rx_valid_o = 1'b0;
    rx_frame_end_o = 1'b0;
    rx_crc_ok_o = 1'b0;
    tx_ready_o = 1'b1;
  end
  // ----------------
  // Slow consumer drops ready every other cycle
  // ----------------
  always @(negedge clk_i) begin
    ph <= ~ph;
    tx_ready_o <= ~(stall_i & ph);
  end
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) got.push_back({tx_last_i, tx_byte_i});
  end
  task automatic req(input logic [7:0] sa, fn, input logic [15:0] rn, cnt, input logic ok);
    logic [15:0] fa;
    logic [7:0] b[6];
    fa = rn - 16'h0001;
    b = '{sa, fn, fa[15:8], fa[7:0], cnt[15:8], cnt[7:0]};
    got.delete();
    for (int i = 0; i < 6; i++) begin
      @(negedge clk_i);
      rx_byte_o = b[i];
      rx_valid_o = 1'b1;
    end
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_byte_o = ~rx_byte_o;
    rx_frame_end_o = 1'b1;
    rx_crc_ok_o = ok;
    @(negedge clk_i);
    rx_frame_end_o = 1'b0;
  endtask
endmodule // mdr_master
`default_nettype wire

/* File: verif/mdr_reader_tb.sv */
// Self-checking bench for the dataset reader
`timescale 1ns/10ps
`default_nettype none
module mdr_reader_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cmd_we_i = 1'b0, upd_i = 1'b0, stall = 1'b0, ph_ok = 1'b1;
  logic ce = 1'b1;
  logic [8:0] cmd_addr_i = 9'h000;
  logic [15:0] cmd_data_i = 16'h0000, vf = 16'h00A5;
  logic [31:0] ph_val = 32'h440AC000;
  logic [7:0] tx_byte_o, rx_byte;
  logic tx_valid_o, tx_last_o, busy_o, rx_valid, rx_end, rx_ok, ready;
  logic [95:0] rows[12], r;
  int checks = 0, n_fail = 0, cyc = 0;
  always #20 clk_i = ~clk_i;
  mdr_reader mdr_reader_inst (.clk_i, .rst_i, .ce_i(ce), .slave_addr_i(8'hFF),
    .rx_byte_i(rx_byte), .rx_valid_i(rx_valid), .rx_frame_end_i(rx_end), .rx_crc_ok_i(rx_ok),
    .cmd_we_i, .cmd_addr_i, .cmd_data_i, .open_closed_contact_i(16'h0021), .status_valid_i(vf),
    .phase1_rms_current_i(ph_val), .phase1_rms_current_ok_i(ph_ok), .upd_i,
    .tx_ready_i(ready), .tx_byte_o, .tx_valid_o, .tx_last_o, .busy_o);
  mdr_master mdr_master_inst (.clk_i, .stall_i(stall), .tx_byte_i(tx_byte_o),
    .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
    .rx_frame_end_o(rx_end), .rx_crc_ok_o(rx_ok), .tx_ready_o(ready));
  task automatic chk(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 32'h0000_4E20) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic pulse(input logic [8:0] a, input logic [15:0] d, input logic we);
    @(negedge clk_i);
    {cmd_addr_i, cmd_data_i, cmd_we_i, upd_i} = {a, d, we, ~we};
    @(negedge clk_i);
    {cmd_we_i, upd_i} = 2'b00;
  endtask
  task automatic run(input logic [7:0] sa, fn, input logic [15:0] rn, cnt, input logic ok);
    int k;
    k = 0;
    mdr_master_inst.req(sa, fn, rn, cnt, ok);
    while (busy_o === 1'b1 && k < 2000) begin
      @(negedge clk_i);
      k++;
    end
    @(negedge clk_i);
  endtask
  task automatic rsp(input logic [7:0] fe, b2, n, input logic [31:0] d);
    logic [8:0] g[$];
    g = mdr_master_inst.got;
    chk(g.size(), n);
    if (g.size() == n) begin
      chk({g[0], g[1], g[2]}, {9'h0FF, 1'b0, fe, n == 8'h03, b2});
      if (n > 8'h06) chk({g[3][7:0], g[4][7:0], g[5][7:0], g[6][7:0]}, d);
      chk(g[n-1][8], 1'b1);
    end
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    rows = '{96'h03_7D00_0002_03_04_07_00A50021, 96'h03_7D1C_0002_03_04_07_440AC000,
      96'h03_7D60_0004_03_08_0B_01020304, 96'h03_7D61_0002_83_02_03_00000000,
      96'h03_7D00_0000_83_03_03_00000000, 96'h03_7D00_007E_83_03_03_00000000,
      96'h03_7D00_007D_03_FA_FD_00A50021, 96'h03_7E54_0002_03_04_07_CAFEF00D,
      96'h03_7E55_0002_83_02_03_00000000, 96'h03_7CFF_0001_83_02_03_00000000,
      96'h06_7D00_0001_86_01_03_00000000, 96'h04_7D00_0001_84_01_03_00000000};
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    chk({tx_byte_o, tx_valid_o, tx_last_o, busy_o}, 32'h0000_0000);
    pulse(9'h060, 16'h0102, 1'b1);
    pulse(9'h061, 16'h0304, 1'b1);
    pulse(9'h154, 16'hCAFE, 1'b1);
    pulse(9'h155, 16'hF00D, 1'b1);
    pulse(9'h000, 16'h0000, 1'b0);
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      stall = i[0];
      run(8'hFF, r[95:88], r[87:72], r[71:56], 1'b1);
      rsp(r[55:48], r[47:40], r[39:32], r[31:0]);
    end
    run(8'hFE, 8'h03, 16'h7D00, 16'h0001, 1'b1);
    chk(mdr_master_inst.got.size(), 0);
    run(8'hFF, 8'h03, 16'h7D00, 16'h0001, 1'b0);
    chk(mdr_master_inst.got.size(), 0);
    {ph_ok, vf} = {1'b0, 16'hFFFF};
    pulse(9'h000, 16'h0000, 1'b0);
    {ph_ok, ph_val} = {1'b1, 32'h3F800000};
    run(8'hFF, 8'h03, 16'h7D1C, 16'h0002, 1'b1);
    rsp(8'h03, 8'h04, 8'h07, 32'hFFC00000);
    run(8'hFF, 8'h03, 16'h7D00, 16'h0002, 1'b1);
    rsp(8'h03, 8'h04, 8'h07, 32'hFFFF0021);
    pulse(9'h000, 16'h0000, 1'b0);
    run(8'hFF, 8'h03, 16'h7D1C, 16'h0002, 1'b1);
    rsp(8'h03, 8'h04, 8'h07, 32'h3F800000);
    chk(8'({mdr_master_inst.got[3][6:0], mdr_master_inst.got[4][7]} - 8'h7F), 32'h0);
    // ----------------
    // Frozen by clock enable, then reset while idle
    // ----------------
    ce = 1'b0;
    run(8'hFF, 8'h03, 16'h7D00, 16'h0001, 1'b1);
    chk(mdr_master_inst.got.size(), 0);
    ce = 1'b1;
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    chk({tx_byte_o, tx_valid_o, tx_last_o, busy_o}, 32'h0000_0000);
    run(8'hFF, 8'h03, 16'h7D1C, 16'h0002, 1'b1);
    rsp(8'h03, 8'h04, 8'h07, 32'hFFC00000);
    run(8'hFF, 8'h03, 16'h7D00, 16'h0002, 1'b1);
    rsp(8'h03, 8'h04, 8'h07, 32'h00000000);
    end_sim();
  end
endmodule // mdr_reader_tb
`default_nettype wire
